// [core/ipc_params.svh]
/*
  Offsets, field positions, reset values and sizes of the pending and
  priority controller. Assumes a 12-bit byte address relative to the
  controller's base and 32-bit word transfers only.
*/
`ifndef IPC_PARAMS_SVH
`define IPC_PARAMS_SVH

// Number of request lines, width of an interrupt number and of a register address
`define IPC_NUM_IRQ 32
`define IPC_ID_W 5
`define IPC_ADDR_W 12

// Register byte offsets
`define IPC_OFS_SET_ENABLE 12'h100
`define IPC_OFS_CLR_ENABLE 12'h180
`define IPC_OFS_SET_PENDING 12'h200
`define IPC_OFS_CLR_PENDING 12'h280
`define IPC_OFS_ACTIVE 12'h300
`define IPC_OFS_LEVEL_MODE 12'h304
`define IPC_OFS_STATUS 12'h308
`define IPC_OFS_PRIO_FIRST 12'h400
`define IPC_OFS_PRIO_LAST 12'h41C

// Priority field: top two bits of each byte lane
`define IPC_PRIO_W 2
`define IPC_PRIO_LANE_W 8
`define IPC_PRIO_LSB 6
`define IPC_PRIO_MSB 7
`define IPC_LANES 4

// Reset values
`define IPC_RST_ENABLE 32'h0000_0000
`define IPC_RST_LEVEL_MODE 32'hFFFF_FFFF
`define IPC_RST_PRIO 2'h0

// Running level when nothing is active: below every real priority
`define IPC_IDLE_LEVEL 3'h4

// Stages of the request line synchroniser
`define IPC_SYNC_STAGES 2

`endif

// [core/ipc_pkg.sv]
/*
  Types shared by the pending and priority controller and its slot.
  Assumes the constants of ipc_params.svh.
*/
`include "ipc_params.svh"

package ipc_pkg;

  // State of one interrupt
  typedef struct packed {
    logic pending;
    logic active;
  } ipc_irq_state_t;

  // One event from the core: entry to or return from a service routine
  typedef struct packed {
    logic valid;
    logic [`IPC_ID_W-1:0] id;
  } ipc_core_evt_t;

  // The request presented to the core
  typedef struct packed {
    logic valid;
    logic [`IPC_ID_W-1:0] id;
    logic [`IPC_PRIO_W-1:0] prio;
  } ipc_core_req_t;

endpackage : ipc_pkg

// [core/ipc_slot.sv]
/*
  Pending and active state of one interrupt.
  Assumes a request level already synchronised to clk_sys_i, a rising edge
  flag derived from it, and one-cycle strobes from software and the core.
*/
`timescale 1ns/1ps

module ipc_slot (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic req_i,
  input wire logic req_rise_i,
  input wire logic level_mode_i,
  input wire logic sw_set_i,
  input wire logic sw_clr_i,
  input wire logic take_i,
  input wire logic return_i,
  output ipc_pkg::ipc_irq_state_t state_o
);
  import ipc_pkg::*;

  ipc_irq_state_t state;
  ipc_irq_state_t next_state;

  // Clears are applied first so that any set in the same cycle wins
  always_comb begin
    next_state = state;
    if (sw_clr_i) begin
      if (!level_mode_i || !req_i) begin
        next_state.pending = 1'b0;
      end
    end
    if (return_i) begin
      next_state.active = 1'b0;
      if (level_mode_i) begin
        next_state.pending = req_i;
      end
    end
    if (take_i) begin
      next_state.pending = 1'b0;
      next_state.active = 1'b1;
    end
    // A held level re-pends only once the routine is no longer active
    if (level_mode_i && req_i && !next_state.active) begin
      next_state.pending = 1'b1;
    end
    if (req_rise_i) begin
      next_state.pending = 1'b1;
    end
    if (sw_set_i) begin
      next_state.pending = 1'b1;
    end
  end

  // Enable plays no part here: disabled lines still pend
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign state_o = state;

endmodule : ipc_slot

// [core/ipc_ctrl.sv]
/*
  Pending, active and priority tracking for a small vectored interrupt
  controller with 32 request lines.
  Assumes request lines arrive from other clock domains, software uses a
  plain register port with one-cycle strobes, and the core reports entry
  to and return from service routines as one-cycle events on clk_sys_i.

*/
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "ipc_params.svh"

module ipc_ctrl (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Peripheral request lines, asynchronous to clk_sys_i
  input wire logic [`IPC_NUM_IRQ-1:0] irq_i,
  // Register port
  input wire logic [`IPC_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Core side
  input ipc_pkg::ipc_core_evt_t core_take_i,
  input ipc_pkg::ipc_core_evt_t core_return_i,
  output ipc_pkg::ipc_core_req_t core_req_o,
  output logic pending_any_o
);
  import ipc_pkg::*;

  localparam int NUM = `IPC_NUM_IRQ;
  localparam int WORDS = `IPC_NUM_IRQ / `IPC_LANES;

  // Synchroniser and edge detector state
  logic [NUM-1:0] sync_meta;
  logic [NUM-1:0] sync_level;
  logic [NUM-1:0] level_prev;
  logic [NUM-1:0] next_sync_meta;
  logic [NUM-1:0] next_sync_level;
  logic [NUM-1:0] next_level_prev;
  logic [NUM-1:0] req_rise;

  // Software visible configuration
  logic [NUM-1:0] enable;
  logic [NUM-1:0] level_mode;
  logic [`IPC_PRIO_W-1:0] prio [NUM];
  logic [NUM-1:0] next_enable;
  logic [NUM-1:0] next_level_mode;
  logic [`IPC_PRIO_W-1:0] next_prio [NUM];

  // Per-interrupt strobes and state
  logic [NUM-1:0] sw_set;
  logic [NUM-1:0] sw_clr;
  logic [NUM-1:0] take_vec;
  logic [NUM-1:0] return_vec;
  ipc_irq_state_t irq_state [NUM];
  logic [NUM-1:0] pending_vec;
  logic [NUM-1:0] active_vec;

  // Register read path
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // Arbitration
  ipc_core_req_t req;
  ipc_core_req_t next_req;
  logic pend_any;
  logic next_pend_any;
  logic [2:0] running_level;

  // Decoded register hits
  logic hit_set_en;
  logic hit_clr_en;
  logic hit_set_pend;
  logic hit_clr_pend;
  logic hit_active;
  logic hit_mode;
  logic hit_status;
  logic hit_prio;
  logic [2:0] prio_word;

  // Every request line passes two flip-flops before anything reads it
  always_comb begin
    next_sync_meta = irq_i;
    next_sync_level = sync_meta;
    next_level_prev = sync_level;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_meta <= '0;
      sync_level <= '0;
      level_prev <= '0;
    end else begin
      sync_meta <= next_sync_meta;
      sync_level <= next_sync_level;
      level_prev <= next_level_prev;
    end
  end

  // Edge of the synchronised level; a one-cycle pulse still shows here
  assign req_rise = sync_level & ~level_prev;

  // Address decode; only whole aligned words are recognised
  always_comb begin
    hit_set_en = (reg_addr_i == `IPC_OFS_SET_ENABLE);
    hit_clr_en = (reg_addr_i == `IPC_OFS_CLR_ENABLE);
    hit_set_pend = (reg_addr_i == `IPC_OFS_SET_PENDING);
    hit_clr_pend = (reg_addr_i == `IPC_OFS_CLR_PENDING);
    hit_active = (reg_addr_i == `IPC_OFS_ACTIVE);
    hit_mode = (reg_addr_i == `IPC_OFS_LEVEL_MODE);
    hit_status = (reg_addr_i == `IPC_OFS_STATUS);
    hit_prio = (reg_addr_i >= `IPC_OFS_PRIO_FIRST) &&
               (reg_addr_i <= `IPC_OFS_PRIO_LAST) &&
               (reg_addr_i[1:0] == 2'h0);
    prio_word = reg_addr_i[4:2];
  end

  // Write strobes toward each slot; set and clear are one-cycle pulses
  always_comb begin
    sw_set = (reg_wr_i && hit_set_pend) ? reg_wdata_i : '0;
    sw_clr = (reg_wr_i && hit_clr_pend) ? reg_wdata_i : '0;
  end

  // Core events decoded to one bit per interrupt
  always_comb begin
    take_vec = '0;
    return_vec = '0;
    if (core_take_i.valid) begin
      take_vec[core_take_i.id] = 1'b1;
    end
    if (core_return_i.valid) begin
      return_vec[core_return_i.id] = 1'b1;
    end
  end

  // Configuration registers: enable, detection mode and priorities
  always_comb begin
    next_enable = enable;
    next_level_mode = level_mode;
    for (int i = 0; i < NUM; i++) begin
      next_prio[i] = prio[i];
    end
    if (reg_wr_i) begin
      if (hit_set_en) begin
        next_enable = enable | reg_wdata_i;
      end
      if (hit_clr_en) begin
        next_enable = enable & ~reg_wdata_i;
      end
      if (hit_mode) begin
        next_level_mode = reg_wdata_i;
      end
      if (hit_prio) begin
        // Lane l of word w belongs to interrupt 4w+l; low six bits dropped
        for (int l = 0; l < `IPC_LANES; l++) begin
          next_prio[{prio_word, l[1:0]}] =
            reg_wdata_i[l*`IPC_PRIO_LANE_W+`IPC_PRIO_LSB +: `IPC_PRIO_W];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enable <= `IPC_RST_ENABLE;
      level_mode <= `IPC_RST_LEVEL_MODE;
      for (int i = 0; i < NUM; i++) begin
        prio[i] <= `IPC_RST_PRIO;
      end
    end else begin
      enable <= next_enable;
      level_mode <= next_level_mode;
      for (int i = 0; i < NUM; i++) begin
        prio[i] <= next_prio[i];
      end
    end
  end

  // One state tracker per interrupt
  for (genvar g = 0; g < NUM; g++) begin : g_slot
    ipc_slot u_slot (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .req_i(sync_level[g]),
      .req_rise_i(req_rise[g]),
      .level_mode_i(level_mode[g]),
      .sw_set_i(sw_set[g]),
      .sw_clr_i(sw_clr[g]),
      .take_i(take_vec[g]),
      .return_i(return_vec[g]),
      .state_o(irq_state[g])
    );
    assign pending_vec[g] = irq_state[g].pending;
    assign active_vec[g] = irq_state[g].active;
  end

  // Level of the routines in service; nested entries keep the best one
  always_comb begin
    running_level = `IPC_IDLE_LEVEL;
    for (int i = 0; i < NUM; i++) begin
      if (active_vec[i] && ({1'b0, prio[i]} < running_level)) begin
        running_level = {1'b0, prio[i]};
      end
    end
  end

  // Pick the best enabled pending line; ties go to the lower number.
  // Offered only when it would preempt what is already running.
  always_comb begin
    next_req = '0;
    next_req.prio = 2'h3;
    for (int i = NUM - 1; i >= 0; i--) begin
      if (pending_vec[i] && enable[i] &&
          (!next_req.valid || (prio[i] <= next_req.prio))) begin
        next_req.valid = 1'b1;
        next_req.id = i[`IPC_ID_W-1:0];
        next_req.prio = prio[i];
      end
    end
    if ({1'b0, next_req.prio} >= running_level) begin
      next_req.valid = 1'b0;
    end
    // Withdraw in the cycle the core takes it, so it is not taken twice
    if (core_take_i.valid) begin
      next_req.valid = 1'b0;
    end
    if (!next_req.valid) begin
      next_req.id = '0;
      next_req.prio = '0;
    end
    next_pend_any = |(pending_vec & enable);
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req <= '0;
      pend_any <= 1'b0;
    end else begin
      req <= next_req;
      pend_any <= next_pend_any;
    end
  end

  // Read mux; unmapped addresses return zero, data stands one cycle only
  always_comb begin
    next_rdata = '0;
    if (reg_rd_i) begin
      if (hit_set_en || hit_clr_en) begin
        next_rdata = enable;
      end
      if (hit_set_pend || hit_clr_pend) begin
        next_rdata = pending_vec;
      end
      if (hit_active) begin
        next_rdata = active_vec;
      end
      if (hit_mode) begin
        next_rdata = level_mode;
      end
      if (hit_status) begin
        next_rdata = {20'h0_0000, running_level, req.valid, 1'b0,
                      req.prio, req.id};
      end
      if (hit_prio) begin
        for (int l = 0; l < `IPC_LANES; l++) begin
          next_rdata[l*`IPC_PRIO_LANE_W+`IPC_PRIO_LSB +: `IPC_PRIO_W] =
            prio[{prio_word, l[1:0]}];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_o = rdata;
  assign core_req_o = req;
  assign pending_any_o = pend_any;

endmodule : ipc_ctrl

// [test/ipc_ctrl_assertions.sv]
/* Checker on the ports of ipc_ctrl.
   Assumes the package and ipc_params.svh are compiled first. */
`timescale 1ns/1ps
`include "ipc_params.svh"
module ipc_ctrl_checker (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [`IPC_NUM_IRQ-1:0] irq_i,
  input wire logic [`IPC_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input ipc_pkg::ipc_core_evt_t core_take_i,
  input ipc_pkg::ipc_core_evt_t core_return_i,
  input ipc_pkg::ipc_core_req_t core_req_o,
  input wire logic pending_any_o
);
  import ipc_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // Read data stands only in the cycle after a read strobe
  a_rdata_zero: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data outside its cycle");
  a_prio_low: assert property (
    reg_rd_i && reg_addr_i[11:5] == 7'h20 && reg_addr_i[1:0] == 2'b00
    |=> (reg_rdata_o & 32'h3F3F_3F3F) == 32'h0000_0000)
    else $error("priority low bits not zero");
  a_misalign_zero: assert property (
    reg_rd_i && reg_addr_i[1:0] != 2'b00 |=> reg_rdata_o == 32'h0000_0000)
    else $error("misaligned read not zero");
  a_req_idle: assert property (
    !core_req_o.valid |-> core_req_o.id == 5'h00 && core_req_o.prio == 2'h0)
    else $error("idle offer not zero");
  a_take_drop: assert property (
    core_take_i.valid |=> !core_req_o.valid)
    else $error("offer kept after take");
  a_offer_pend: assert property (
    core_req_o.valid |-> pending_any_o)
    else $error("offer without pending");
  // Set-pending then read back shows every written bit
  a_set_pend: assert property (
    reg_wr_i && reg_addr_i == 12'h200 ##1 reg_rd_i && reg_addr_i == 12'h200
    |=> (reg_rdata_o & $past(reg_wdata_i, 2)) == $past(reg_wdata_i, 2))
    else $error("set-pending not seen");
  // Quiet request lines, so no set event can win over the clear
  a_clr_pend: assert property (
    (irq_i == 32'h0000_0000) [*4] ##0 reg_wr_i && reg_addr_i == 12'h280
    ##1 reg_rd_i && reg_addr_i == 12'h280
    |=> (reg_rdata_o & $past(reg_wdata_i, 2)) == 32'h0000_0000)
    else $error("clear-pending not seen");
endmodule : ipc_ctrl_checker

// [test/ipc_core_model.sv]
/* Core model: takes the offered interrupt, returns when told to.
   Assumes one-cycle events on the design clock. */
`timescale 1ns/1ps
`include "ipc_params.svh"
module ipc_core_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input ipc_pkg::ipc_core_req_t req_i,
  input wire logic auto_i,
  input wire logic ret_i,
  output ipc_pkg::ipc_core_evt_t take_o,
  output ipc_pkg::ipc_core_evt_t return_o,
  output logic busy_o
);
  import ipc_pkg::*;
  logic [`IPC_ID_W-1:0] cur;
  // One routine at a time; a return blocks a take for a cycle so the
  // offer is re-evaluated first
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      take_o <= '0;
      return_o <= '0;
      busy_o <= 1'b0;
      cur <= '0;
    end else begin
      take_o <= '0;
      return_o <= '0;
      if (!busy_o && auto_i && req_i.valid && !return_o.valid) begin
        take_o <= {1'b1, req_i.id};
        cur <= req_i.id;
        busy_o <= 1'b1;
      end else if (busy_o && ret_i && !take_o.valid) begin
        return_o <= {1'b1, cur};
        busy_o <= 1'b0;
      end
    end
  end
endmodule : ipc_core_model

// [test/testbench.sv]
/* Self-checking bench for ipc_ctrl with a core model.
   Assumes the core files and the checker are compiled first. */
`timescale 1ns/1ps
module testbench;
  import ipc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] irq = 32'h0000_0000;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic auto = 1'b0;
  logic ret = 1'b0;
  logic [31:0] rdata;
  logic busy;
  logic pend_any;
  ipc_core_evt_t take;
  ipc_core_evt_t retn;
  ipc_core_req_t req;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  ipc_ctrl dut_u (.clk_sys_i(clk), .rstn_i(rstn), .irq_i(irq),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .core_take_i(take),
    .core_return_i(retn), .core_req_o(req), .pending_any_o(pend_any));
  ipc_core_model core_u (.clk_i(clk), .rstn_i(rstn), .req_i(req),
    .auto_i(auto), .ret_i(ret), .take_o(take), .return_o(retn),
    .busy_o(busy));

  // Clock and a hang guard well above the fewer than two hundred cycles needed
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // One write, one read, or a write then a read back to back
  task bus(input logic w, input logic r, input logic [11:0] a,
    input logic [31:0] d, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= r & ~w;
    if (w && r) begin
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
    end
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    if (r) begin
      #1;
      chk(rdata & m, e);
    end
  endtask : bus

  task wait_busy(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(busy), 32'(v));
  endtask : wait_busy

  task pulse(input int n);
    @(posedge clk);
    irq[n] <= 1'b1;
    @(posedge clk);
    irq[n] <= 1'b0;
  endtask : pulse

  task serve_end;
    @(posedge clk);
    auto <= 1'b0;
    ret <= 1'b1;
    wait_busy(1'b0);
    @(posedge clk);
    ret <= 1'b0;
  endtask : serve_end

  task t_prio;
    logic [31:0] pat;
    for (int w = 0; w < 8; w++) begin
      pat = 32'(32'h9E37_79B9 * (w + 1));
      bus(1, 0, 12'(12'h400 + 4 * w), pat, 0, 0);
    end
    // Only bits 7..6 of each lane survive the round trip
    for (int w = 0; w < 8; w++) begin
      pat = 32'(32'h9E37_79B9 * (w + 1));
      bus(0, 1, 12'(12'h400 + 4 * w), 0, pat & 32'hC0C0_C0C0,
        32'hFFFF_FFFF);
    end
    bus(1, 0, 12'h400, 0, 0, 0);
    bus(1, 0, 12'h404, 32'h0000_0080, 0, 0);
    bus(1, 0, 12'h408, 32'h0000_0040, 0, 0);
    $display("t_prio done");
  endtask : t_prio

  task t_sw;
    bus(1, 1, 12'h200, 32'h0000_0200, 32'h0000_0200, 32'h0000_0200);
    repeat (3) @(posedge clk);
    #1;
    chk(32'({req.valid, pend_any}), 32'h0000_0000);
    bus(1, 0, 12'h100, 32'h0000_0138, 0, 0);
    bus(1, 1, 12'h200, 32'h0000_0110, 32'h0000_0310, 32'h0000_0FFF);
    #1;
    chk(32'(req), 32'h0000_00A1);
    chk(32'(pend_any), 32'h0000_0001);
    // Status shows idle level 4, offer valid, prio 1, id 8
    bus(0, 1, 12'h308, 0, 32'h0000_0928, 32'h0000_0FFF);
    // Disabling line 8 hands the offer to line 4 at prio 2
    bus(1, 0, 12'h180, 32'h0000_0100, 0, 0);
    @(posedge clk);
    #1;
    chk(32'(req), 32'h0000_0092);
    bus(0, 1, 12'h180, 0, 32'h0000_0038, 32'hFFFF_FFFF);
    bus(1, 1, 12'h280, 32'hFFFF_FFFF, 0, 32'hFFFF_FFFF);
    bus(0, 1, 12'h500, 0, 0, 32'hFFFF_FFFF);
    bus(0, 1, 12'h202, 0, 0, 32'hFFFF_FFFF);
    $display("t_sw done");
  endtask : t_sw

  task t_level;
    @(posedge clk);
    auto <= 1'b1;
    irq[3] <= 1'b1;
    wait_busy(1'b1);
    bus(0, 1, 12'h300, 0, 32'h0000_0008, 32'h0000_0008);
    bus(0, 1, 12'h200, 0, 0, 32'h0000_0008);
    bus(1, 0, 12'h280, 32'h0000_0008, 0, 0);
    bus(0, 1, 12'h300, 0, 32'h0000_0008, 32'h0000_0008);
    serve_end();
    bus(0, 1, 12'h200, 0, 32'h0000_0008, 32'h0000_0008);
    bus(1, 1, 12'h280, 32'h0000_0008, 32'h0000_0008, 32'h0000_0008);
    @(posedge clk);
    irq[3] <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1, 1, 12'h280, 32'h0000_0008, 0, 32'h0000_0008);
    $display("t_level done");
  endtask : t_level

  task t_pulse;
    bus(1, 0, 12'h304, 32'hFFFF_FFDF, 0, 0);
    bus(0, 1, 12'h304, 0, 32'hFFFF_FFDF, 32'hFFFF_FFFF);
    @(posedge clk);
    auto <= 1'b1;
    pulse(5);
    wait_busy(1'b1);
    pulse(5);
    repeat (4) @(posedge clk);
    bus(0, 1, 12'h200, 0, 32'h0000_0020, 32'h0000_0020);
    bus(0, 1, 12'h300, 0, 32'h0000_0020, 32'h0000_0020);
    bus(1, 1, 12'h280, 32'h0000_0020, 0, 32'h0000_0020);
    bus(0, 1, 12'h300, 0, 32'h0000_0020, 32'h0000_0020);
    pulse(5);
    repeat (4) @(posedge clk);
    serve_end();
    bus(0, 1, 12'h200, 0, 32'h0000_0020, 32'h0000_0020);
    bus(1, 1, 12'h280, 32'h0000_0020, 0, 32'h0000_0020);
    bus(0, 1, 12'h300, 0, 0, 32'h0000_0020);
    bus(1, 0, 12'h200, 32'h0000_0020, 0, 0);
    @(posedge clk);
    auto <= 1'b1;
    wait_busy(1'b1);
    serve_end();
    bus(0, 1, 12'h300, 0, 0, 32'h0000_0020);
    bus(0, 1, 12'h200, 0, 0, 32'h0000_0020);
    $display("t_pulse done");
  endtask : t_pulse

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  // Reset, then the scenarios in turn
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_prio();
    t_sw();
    t_level();
    t_pulse();
    end_of_test();
  end
endmodule : testbench

bind ipc_ctrl ipc_ctrl_checker chk_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
  .irq_i(irq_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .core_take_i(core_take_i), .core_return_i(core_return_i),
  .core_req_o(core_req_o), .pending_any_o(pending_any_o));
